/* File: hw/qec_top.sv */
// Quadrature encoder configuration, input conditioning and position counter
//
// What this block does
// - Module enable clear stops counters; registers stay readable and writable.
// - Stop-in-idle set halts counting while idle; clear keeps counting.
// - Counter modes 10 (ext gate) and 11 (timer) ignore init mode.
// - Quadrature mode: index match on A/B pattern clears the position counter.
// - Init 000 ignores index outside quadrature mode, 001 clears each index, 010 loads next index.
// - Init 011 loads on first index after home, 100 on second.
// - Init 101 clears position when it equals the upper compare value.
// - Init 110 counts modulo; 111 adds clear on every index.
// - Index match pattern bits 9:8 give required B and A levels.
// - Prescale bits 6:4 divide internal counting clock 1 to 256.
// - Direction bit selects default down or up; external up/down overrides.
// - Gate enable makes external gate control counting; clear ignores it except in ext gate mode.
// - Counter mode bits 1:0 select quadrature, ext up/down, ext gate, timer.
// - Index capture enable: rising index match captures the position.
// - Filter enable passes A, B, index, home through a digital filter.
// - Output function bits 10:9 drive the compare output pin.
// - Swap bit exchanges A and B before the decoder.
// - Home polarity bit inverts the home input.
// - Bits 6, 5, 4 invert index, B and A inputs.
// - Read-only bits 3:0 show home, index, B, A after polarity and swap.
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`default_nettype none

module qec_top
    import qec_pkg::*;
#(
    parameter int POS_W = 32
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [QEC_ADDR_W-1:0] reg_addr_i,
    input wire logic [QEC_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [QEC_DATA_W-1:0] reg_rdata_o,
    input wire logic cpu_idle_i,
    input wire logic phase_a_input_i,
    input wire logic phase_b_input_i,
    input wire logic marker_input_i,
    input wire logic reference_switch_input_i,
    input wire logic [POS_W-1:0] init_value_register_i,
    input wire logic [POS_W-1:0] upper_compare_value_i,
    input wire logic [POS_W-1:0] lower_compare_value_i,
    output logic [POS_W-1:0] position_counter_o,
    output logic [POS_W-1:0] position_hold_o,
    output logic position_capture_o,
    output logic compare_output_pin_o
);

    if (POS_W < 2 || POS_W > 32) begin : g_bad_width
        $error("qec_top: POS_W must lie between 2 and 32");
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [15:0] ctrl_q, ioc_q, rdata_q;
    logic [3:0] status_lvl;
    logic wr_ctrl, wr_ioc;
    assign wr_ctrl = reg_wr_i && (reg_addr_i == QEC_OFF_CONTROL);
    assign wr_ioc = reg_wr_i && (reg_addr_i == QEC_OFF_INPUT_CONTROL);
    // Configuration fields
    wire logic module_enable_bit = ctrl_q[QEC_MODULE_ENABLE_BIT];
    wire logic stop_in_idle_bit = ctrl_q[QEC_STOP_IN_IDLE_BIT];
    wire logic [2:0] position_init_mode = ctrl_q[QEC_PIMOD_LSB +: 3];
    wire logic [1:0] index_match_pattern = ctrl_q[QEC_IMV_LSB +: 2];
    wire logic [2:0] counter_clock_prescale = ctrl_q[QEC_PRESCALE_LSB +: 3];
    wire logic count_direction_select = ctrl_q[QEC_DIRECTION_BIT];
    wire logic gate_enable_bit = ctrl_q[QEC_GATE_ENABLE_BIT];
    wire logic [1:0] counter_control_mode = ctrl_q[QEC_CCM_LSB +: 2];
    wire logic index_capture_enable = ioc_q[QEC_INDEX_CAPTURE_BIT];
    wire logic input_filter_enable = ioc_q[QEC_FILTER_ENABLE_BIT];
    wire logic [2:0] filter_clock_divide = ioc_q[QEC_FILTER_DIV_LSB +: 3];
    wire logic [1:0] compare_output_function = ioc_q[QEC_OUTFNC_LSB +: 2];
    wire logic phase_swap_bit = ioc_q[QEC_SWAP_BIT];
    // Order: home, index, B, A
    wire logic [3:0] pol_bits = {ioc_q[QEC_HOME_POL_BIT], ioc_q[QEC_INDEX_POL_BIT],
                                 ioc_q[QEC_B_POL_BIT], ioc_q[QEC_A_POL_BIT]};

    // Control register writes, reserved bits held at zero
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_q <= QEC_CONTROL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= reg_wdata_i & QEC_CONTROL_WMASK;
        end
    end
    // Input control register writes, low four bits are live status
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ioc_q <= QEC_INPUT_CONTROL_RESET;
        end else if (wr_ioc) begin
            ioc_q <= reg_wdata_i & QEC_INPUT_CONTROL_WMASK;
        end
    end
    // Read data valid only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_q <= 16'h0000;
        end else if (reg_rd_i && reg_addr_i == QEC_OFF_CONTROL) begin
            rdata_q <= ctrl_q;
        end else if (reg_rd_i && reg_addr_i == QEC_OFF_INPUT_CONTROL) begin
            rdata_q <= {ioc_q[15:4], status_lvl};
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers, swap and polarity
    logic [3:0] pin_raw, sync1_q, sync2_q, swapped;
    assign pin_raw = {reference_switch_input_i, marker_input_i,
                      phase_b_input_i, phase_a_input_i};

    // Two-stage synchroniser on the four encoder pins
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end

    // A and B exchanged ahead of polarity and decoder
    assign swapped = phase_swap_bit ? {sync2_q[3:2], sync2_q[0], sync2_q[1]}
                                    : sync2_q;
    assign status_lvl = swapped ^ pol_bits;

    ////////////////////////////////////////////////////////////////////////
    // Clock dividers for the filter and the internal counting clock
    logic [QEC_DIV_W-1:0] div_cnt_q;
    logic flt_tick, cnt_tick;
    // Free-running divider shared by both prescalers
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_cnt_q <= '0;
        end else begin
            div_cnt_q <= div_cnt_q + 8'h01;
        end
    end

    assign flt_tick = (div_cnt_q & qec_div_mask(filter_clock_divide)) == 8'h00;
    assign cnt_tick = (div_cnt_q & qec_div_mask(counter_clock_prescale)) == 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Digital filter: an input changes after three equal samples
    logic [3:0] filt_q, cond;
    for (genvar i = 0; i < 4; i++) begin : g_filter
        logic [QEC_FILTER_DEPTH-1:0] hist_q;
        // Sample history on each filter clock tick
        always_ff @(posedge mclk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                hist_q <= '0;
                filt_q[i] <= 1'b0;
            end else if (flt_tick) begin
                hist_q <= {hist_q[QEC_FILTER_DEPTH-2:0], status_lvl[i]};
                filt_q[i] <= (&hist_q) || (filt_q[i] && (|hist_q));
            end
        end
        assign cond[i] = input_filter_enable ? filt_q[i] : status_lvl[i];
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge detection and event decode
    logic [3:0] prev_q;
    logic idx_match_q, idx_match, idx_event, home_event, count_run;
    logic step_valid, step_up, quad_step, quad_dir, gate_level;
    // Previous conditioned levels
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prev_q <= 4'h0;
            idx_match_q <= 1'b0;
        end else begin
            prev_q <= cond;
            idx_match_q <= idx_match;
        end
    end

    // Index qualified by the A/B pattern in quadrature mode
    assign idx_match = (counter_control_mode == QEC_CCM_QUADRATURE)
                     ? cond[2] && (cond[1:0] == index_match_pattern)
                     : cond[2];
    assign idx_event = idx_match && !idx_match_q;
    assign home_event = cond[3] && !prev_q[3];
    // Enable and idle gating of the position counter, homing and capture; the divider runs free
    assign count_run = module_enable_bit && !(stop_in_idle_bit && cpu_idle_i);
    assign gate_level = cond[1];
    // Quadrature decoder: one phase change per step, A leading B counts up
    assign quad_step = (cond[0] ^ prev_q[0]) ^ (cond[1] ^ prev_q[1]);
    assign quad_dir = prev_q[1] ^ cond[0];
    // Counting source per counter control mode
    always_comb begin
        step_valid = 1'b0;
        step_up = !count_direction_select;
        case (counter_control_mode)
            QEC_CCM_QUADRATURE: begin
                step_valid = quad_step;
                step_up = quad_dir ^ count_direction_select;
            end
            QEC_CCM_EXT_UPDOWN: begin
                step_valid = cond[0] && !prev_q[0];
                step_up = cond[1];
            end
            QEC_CCM_EXT_GATE: step_valid = cond[0] && !prev_q[0] && gate_level;
            QEC_CCM_TIMER: step_valid = cnt_tick;
            default: step_valid = 1'b0;
        endcase
        if (gate_enable_bit && !gate_level) begin
            step_valid = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Homing sequence for the home-qualified load modes
    qec_home_e home_q;
    logic home_load, next_loaded_q, pi_active;
    // Ext gate and timer modes take no notice of the initialisation mode
    assign pi_active = !counter_control_mode[1];
    // Load strobe for modes 011 and 100
    assign home_load = idx_event
        && ((position_init_mode == QEC_PI_HOME_FIRST && home_q == QEC_H_WAIT_FIRST)
        || (position_init_mode == QEC_PI_HOME_SECOND && home_q == QEC_H_WAIT_SECOND));
    // Home then index sequencing; rearmed by a control register write
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            home_q <= QEC_H_WAIT_HOME;
        end else if (wr_ctrl) begin
            home_q <= QEC_H_WAIT_HOME;
        end else if (count_run && pi_active) begin
            case (home_q)
                QEC_H_WAIT_HOME: begin
                    if (home_event) begin
                        home_q <= QEC_H_WAIT_FIRST;
                    end
                end
                QEC_H_WAIT_FIRST: begin
                    if (home_load) begin
                        home_q <= QEC_H_DONE;
                    end else if (idx_event) begin
                        home_q <= QEC_H_WAIT_SECOND;
                    end
                end
                QEC_H_WAIT_SECOND: begin
                    if (idx_event) begin
                        home_q <= QEC_H_DONE;
                    end
                end
                QEC_H_DONE: home_q <= QEC_H_DONE;
                default: home_q <= QEC_H_WAIT_HOME;
            endcase
        end
    end

    // One-shot load in mode 010, rearmed by a control register write
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            next_loaded_q <= 1'b0;
        end else if (count_run && pi_active && idx_event
                     && position_init_mode == QEC_PI_NEXT_INDEX_LOAD) begin
            next_loaded_q <= 1'b1;
        end else if (wr_ctrl) begin
            next_loaded_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Position counter
    logic [POS_W-1:0] pos_q, pos_step;
    logic idx_clear;
    // Index clear: modes 001 and 111, or any index match in quadrature mode
    assign idx_clear = idx_event && (position_init_mode == QEC_PI_INDEX_CLEAR
                     || position_init_mode == QEC_PI_MODULO_INDEX
                     || counter_control_mode == QEC_CCM_QUADRATURE);
    // Next value after a single step, modulo wrap in modes 110 and 111
    always_comb begin
        pos_step = step_up ? pos_q + 1'b1 : pos_q - 1'b1;
        if (pi_active && position_init_mode[2:1] == 2'b11) begin
            if (step_up && pos_q == upper_compare_value_i) begin
                pos_step = lower_compare_value_i;
            end else if (!step_up && pos_q == lower_compare_value_i) begin
                pos_step = upper_compare_value_i;
            end
        end
    end

    // Initialisation events take priority over counting
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pos_q <= '0;
        end else if (count_run) begin
            if (pi_active && home_load) begin
                pos_q <= init_value_register_i;
            end else if (pi_active && idx_event && !next_loaded_q
                         && position_init_mode == QEC_PI_NEXT_INDEX_LOAD) begin
                pos_q <= init_value_register_i;
            end else if (pi_active && idx_clear) begin
                pos_q <= '0;
            end else if (pi_active && position_init_mode == QEC_PI_GEC_CLEAR
                         && pos_q == upper_compare_value_i) begin
                pos_q <= '0;
            end else if (step_valid) begin
                pos_q <= pos_step;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Capture on rising index match
    logic [POS_W-1:0] hold_q;
    logic cap_q;
    // Position captured and strobe raised for one cycle
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hold_q <= '0;
            cap_q <= 1'b0;
        end else begin
            cap_q <= 1'b0;
            if (count_run && index_capture_enable && idx_event) begin
                hold_q <= pos_q;
                cap_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare output pin
    logic cmp_q, at_or_above, at_or_below;
    assign at_or_above = pos_q >= upper_compare_value_i;
    assign at_or_below = pos_q <= lower_compare_value_i;
    // Registered compare function
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmp_q <= 1'b0;
        end else begin
            case (compare_output_function)
                QEC_OUT_GE: cmp_q <= at_or_above;
                QEC_OUT_LE: cmp_q <= at_or_below;
                QEC_OUT_EITHER: cmp_q <= at_or_above || at_or_below;
                default: cmp_q <= 1'b0;
            endcase
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata_o = rdata_q;
    assign position_counter_o = pos_q;
    assign position_hold_o = hold_q;
    assign position_capture_o = cap_q;
    assign compare_output_pin_o = cmp_q;

endmodule

`default_nettype wire

/* File: pkg/qec_pkg.sv */
// Register map, field positions and constants of the quadrature encoder block
package qec_pkg;

    // Register offsets and bus widths
    localparam int QEC_ADDR_W = 12;
    localparam int QEC_DATA_W = 16;
    localparam logic [11:0] QEC_OFF_CONTROL = 12'h140;
    localparam logic [11:0] QEC_OFF_INPUT_CONTROL = 12'h144;

    // Reset values and writable masks
    localparam logic [15:0] QEC_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] QEC_INPUT_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] QEC_CONTROL_WMASK = 16'hbf7f;
    localparam logic [15:0] QEC_INPUT_CONTROL_WMASK = 16'hfff0;

    // Encoder control fields
    localparam int QEC_MODULE_ENABLE_BIT = 15;
    localparam int QEC_STOP_IN_IDLE_BIT = 13;
    localparam int QEC_PIMOD_LSB = 10;
    localparam int QEC_IMV_LSB = 8;
    localparam int QEC_PRESCALE_LSB = 4;
    localparam int QEC_DIRECTION_BIT = 3;
    localparam int QEC_GATE_ENABLE_BIT = 2;
    localparam int QEC_CCM_LSB = 0;

    // Input control fields
    localparam int QEC_INDEX_CAPTURE_BIT = 15;
    localparam int QEC_FILTER_ENABLE_BIT = 14;
    localparam int QEC_FILTER_DIV_LSB = 11;
    localparam int QEC_OUTFNC_LSB = 9;
    localparam int QEC_SWAP_BIT = 8;
    localparam int QEC_HOME_POL_BIT = 7;
    localparam int QEC_INDEX_POL_BIT = 6;
    localparam int QEC_B_POL_BIT = 5;
    localparam int QEC_A_POL_BIT = 4;

    // Counter control modes
    localparam logic [1:0] QEC_CCM_QUADRATURE = 2'h0;
    localparam logic [1:0] QEC_CCM_EXT_UPDOWN = 2'h1;
    localparam logic [1:0] QEC_CCM_EXT_GATE = 2'h2;
    localparam logic [1:0] QEC_CCM_TIMER = 2'h3;

    // Position initialisation modes
    localparam logic [2:0] QEC_PI_NONE = 3'h0;
    localparam logic [2:0] QEC_PI_INDEX_CLEAR = 3'h1;
    localparam logic [2:0] QEC_PI_NEXT_INDEX_LOAD = 3'h2;
    localparam logic [2:0] QEC_PI_HOME_FIRST = 3'h3;
    localparam logic [2:0] QEC_PI_HOME_SECOND = 3'h4;
    localparam logic [2:0] QEC_PI_GEC_CLEAR = 3'h5;
    localparam logic [2:0] QEC_PI_MODULO = 3'h6;
    localparam logic [2:0] QEC_PI_MODULO_INDEX = 3'h7;

    // Compare output functions
    localparam logic [1:0] QEC_OUT_OFF = 2'h0;
    localparam logic [1:0] QEC_OUT_GE = 2'h1;
    localparam logic [1:0] QEC_OUT_LE = 2'h2;
    localparam logic [1:0] QEC_OUT_EITHER = 2'h3;

    // Divider and filter sizes
    localparam int QEC_DIV_W = 8;
    localparam int QEC_FILTER_DEPTH = 3;

    // Homing sequence states
    typedef enum logic [1:0] {
        QEC_H_WAIT_HOME,
        QEC_H_WAIT_FIRST,
        QEC_H_WAIT_SECOND,
        QEC_H_DONE
    } qec_home_e;

    // Divide code to low-bit mask: 1,2,4,8,16,32,64,256
    function automatic logic [7:0] qec_div_mask(input logic [2:0] code);
        logic [7:0] m;
        m = 8'h00;
        case (code)
            3'h0: m = 8'h00;
            3'h1: m = 8'h01;
            3'h2: m = 8'h03;
            3'h3: m = 8'h07;
            3'h4: m = 8'h0f;
            3'h5: m = 8'h1f;
            3'h6: m = 8'h3f;
            default: m = 8'hff;
        endcase
        return m;
    endfunction

endpackage

/* File: tb/qec_enc_model.sv */
// Behavioural incremental encoder with marker and reference switch
`timescale 1ns/100ps
`default_nettype none
module qec_enc_model (
    input wire logic clk,
    output logic a,
    output logic b,
    output logic idx,
    output logic home
);
    logic [1:0] ph = 2'h0;
    initial {home, idx, b, a} = 4'h0;
    // One quadrature step, A leads B when going up, then a quiet gap
    task automatic step(input int dir);
        @(posedge clk);
        ph = ph + 2'(dir);
        a <= ph[0] ^ ph[1];
        b <= ph[1];
        repeat (20) @(posedge clk);
    endtask
    // Marker pulse (w low) or reference switch pulse (w high)
    task automatic pulse(input logic w);
        @(posedge clk);
        if (w) home <= 1'b1;
        else idx <= 1'b1;
        repeat (20) @(posedge clk);
        home <= 1'b0;
        idx <= 1'b0;
        repeat (20) @(posedge clk);
    endtask
    // Raw levels on all four lines, phase back to rest
    task automatic set_raw(input logic [3:0] v);
        @(posedge clk);
        {home, idx, b, a} <= v;
        ph = 2'h0;
        repeat (5) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* File: tb/qec_top_monitor.sv */
// Port-level checker for the quadrature encoder block
`timescale 1ns/100ps
`default_nettype none
module qec_top_monitor
    import qec_pkg::*;
#(parameter int POS_W = 32) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [QEC_ADDR_W-1:0] reg_addr_i,
    input wire logic [QEC_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [QEC_DATA_W-1:0] reg_rdata_o,
    input wire logic cpu_idle_i,
    input wire logic phase_a_input_i,
    input wire logic phase_b_input_i,
    input wire logic marker_input_i,
    input wire logic reference_switch_input_i,
    input wire logic [POS_W-1:0] init_value_register_i,
    input wire logic [POS_W-1:0] upper_compare_value_i,
    input wire logic [POS_W-1:0] lower_compare_value_i,
    input wire logic [POS_W-1:0] position_counter_o,
    input wire logic [POS_W-1:0] position_hold_o,
    input wire logic position_capture_o,
    input wire logic compare_output_pin_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    logic [15:0] ctrl_q;
    logic [15:0] ioc_q;
    logic cmp_d;
    logic frozen_d;
    logic tick_d;
    ////////////////////////////////////////////////////////////////
    // Shadow copies of the writable register bits
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_q <= 16'h0000;
            ioc_q <= 16'h0000;
        end else if (reg_wr_i && reg_addr_i == QEC_OFF_CONTROL) begin
            ctrl_q <= reg_wdata_i & QEC_CONTROL_WMASK;
        end else if (reg_wr_i && reg_addr_i == QEC_OFF_INPUT_CONTROL) begin
            ioc_q <= reg_wdata_i & QEC_INPUT_CONTROL_WMASK;
        end
    end
    // Expected compare level, freeze and plain timer tick
    assign cmp_d = (ioc_q[9] && position_counter_o >= upper_compare_value_i)
        || (ioc_q[10] && position_counter_o <= lower_compare_value_i);
    assign frozen_d = !ctrl_q[15] || (ctrl_q[13] && cpu_idle_i);
    assign tick_d = !frozen_d && ctrl_q[1:0] == 2'h3 && ctrl_q[6:2] == 5'h00;
    ////////////////////////////////////////////////////////////////
    a_read_ctrl_value: assert property (
        $past(reg_rd_i && reg_addr_i == QEC_OFF_CONTROL) |-> reg_rdata_o == $past(ctrl_q))
        else $error("control read mismatch");
    a_read_ioc_cfg: assert property (
        $past(reg_rd_i && reg_addr_i == QEC_OFF_INPUT_CONTROL)
        |-> reg_rdata_o[15:4] == $past(ioc_q[15:4])) else $error("input control read mismatch");
    a_read_unmapped_zero: assert property (
        $past(reg_rd_i) && !$past(reg_addr_i == QEC_OFF_CONTROL
        || reg_addr_i == QEC_OFF_INPUT_CONTROL) |-> reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_freeze_hold: assert property (
        frozen_d |=> $stable(position_counter_o)) else $error("counter moved while frozen");
    a_timer_step: assert property (
        tick_d |=> position_counter_o == $past(position_counter_o) + 1)
        else $error("timer step wrong");
    a_compare_pin: assert property (
        compare_output_pin_o == $past(cmp_d)) else $error("compare pin wrong");
    a_capture_value: assert property (
        position_capture_o |-> position_hold_o == $past(position_counter_o))
        else $error("captured value wrong");
    a_capture_enable: assert property (
        position_capture_o |-> $past(ioc_q[15]) ##1 !position_capture_o)
        else $error("capture without enable");
    c_capture: cover property (position_capture_o);
    c_timer: cover property (tick_d);
    c_compare: cover property (compare_output_pin_o);
endmodule
bind qec_top qec_top_monitor #(.POS_W(POS_W)) u_mon (.*);
`default_nettype wire

/* File: tb/qec_top_tb.sv */
// Self-checking testbench for the quadrature encoder block
`timescale 1ns/100ps
`default_nettype none
module qec_top_tb
    import qec_pkg::*;
;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [11:0] reg_addr_i = 12'h000;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic cpu_idle_i = 1'b0;
    logic [31:0] init_value_register_i = 32'h0;
    logic [31:0] upper_compare_value_i = 32'h0;
    logic [31:0] lower_compare_value_i = 32'h0;
    logic [15:0] reg_rdata_o;
    wire phase_a_input_i, phase_b_input_i, marker_input_i, reference_switch_input_i;
    logic [31:0] position_counter_o, position_hold_o, exp_pos, base;
    logic position_capture_o, compare_output_pin_o, sw;
    logic [3:0] pins, pol;
    int num_errors = 0;
    int samples_checked = 0;
    int n;
    qec_top DUT (.*);
    qec_enc_model enc (.clk(mclk_i), .a(phase_a_input_i), .b(phase_b_input_i),
        .idx(marker_input_i), .home(reference_switch_input_i));
    always #2 mclk_i = ~mclk_i;
    ////////////////////////////////////////////////////////////////
    // Compare, register write and register read helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] e);
        @(posedge mclk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1 chk({16'h0, reg_rdata_o}, {16'h0, e});
    endtask
    task automatic end_sim;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Hang guard
    initial begin
        #200000;
        num_errors++;
        end_sim();
    end
    // Main sequence
    initial begin
        void'($urandom(32'h3526));
        repeat (4) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        rd(QEC_OFF_CONTROL, 16'h0000);
        wr(QEC_OFF_CONTROL, 16'h7fff);
        rd(QEC_OFF_CONTROL, 16'h3f7f);
        rd(12'h142, 16'h0000);
        for (int k = 0; k < 6; k++) begin
            pins = 4'($urandom);
            pol = 4'($urandom);
            sw = 1'($urandom);
            wr(QEC_OFF_INPUT_CONTROL, {7'h00, sw, pol, 4'hf});
            enc.set_raw(pins);
            rd(QEC_OFF_INPUT_CONTROL, {7'h00, sw, pol, pins[3] ^ pol[3], pins[2] ^ pol[2],
                (sw ? pins[0] : pins[1]) ^ pol[1], (sw ? pins[1] : pins[0]) ^ pol[0]});
        end
        chk(position_counter_o, 32'h0);
        enc.set_raw(4'h0);
        exp_pos = 32'h0;
        // Direction bit and swap, whole encoder cycles
        for (int c = 0; c < 4; c++) begin
            wr(QEC_OFF_INPUT_CONTROL, 16'(c[1]) << 8);
            wr(QEC_OFF_CONTROL, 16'h8000 | (16'(c[0]) << 3));
            n = 4 * $urandom_range(1, 3);
            repeat (n) enc.step(1);
            exp_pos = exp_pos + ((c[0] ^ c[1]) ? -n : n);
            chk(position_counter_o, exp_pos);
        end
        // Init modes 1 to 4 with filtered inputs, capture only in mode 1
        for (int m = 1; m < 5; m++) begin
            init_value_register_i <= 32'($urandom_range(16, 999));
            wr(QEC_OFF_INPUT_CONTROL, (m == 1) ? 16'hc800 : 16'h4800);
            wr(QEC_OFF_CONTROL, 16'h8000 | 16'(m << 10));
            if (m > 2) enc.pulse(1'b1);
            for (int k = 1; k < 3; k++) begin
                repeat (4) enc.step(1);
                exp_pos = exp_pos + 4;
                chk(position_counter_o, exp_pos);
                enc.pulse(1'b0);
                if (m == 1) chk(position_hold_o, exp_pos);
                sw = (k == 1 && (m == 2 || m == 3)) || (m == 4 && k == 2);
                exp_pos = sw ? init_value_register_i : 32'h0;
                chk(position_counter_o, exp_pos);
            end
        end
        // Compare output functions around the present position
        for (int f = 0; f < 4; f++) begin
            upper_compare_value_i <= exp_pos + $urandom_range(0, 2) - 1;
            lower_compare_value_i <= exp_pos + $urandom_range(0, 2) - 1;
            wr(QEC_OFF_INPUT_CONTROL, 16'(f << 9));
            repeat (3) @(posedge mclk_i);
            #1 chk({31'h0, compare_output_pin_o}, {31'h0, (f[0] && exp_pos >= upper_compare_value_i)
                || (f[1] && exp_pos <= lower_compare_value_i)});
        end
        // External clock on A, direction from B
        wr(QEC_OFF_CONTROL, 16'h8001);
        for (int k = 0; k < 4; k++) enc.set_raw(4'(2 + k % 2));
        chk(position_counter_o, exp_pos + 2);
        // Timer mode: every prescale code, both directions, idle with and without stop
        for (int i = 0; i < 9; i++) begin
            cpu_idle_i <= i[1] | (i == 8);
            wr(QEC_OFF_CONTROL, 16'h8003 | 16'((i % 8) << 4) | (16'(i[0]) << 3)
                | ((i == 8) ? 16'h2000 : 16'h0000));
            @(posedge mclk_i);
            #1 base = position_counter_o;
            repeat (256) @(posedge mclk_i);
            n = (i == 8) ? 0 : 256 >> ((i == 7) ? 8 : i);
            #1 chk(position_counter_o - base, i[0] ? -n : n);
        end
        end_sim();
    end
endmodule
`default_nettype wire
